// ==== inc/rxq2_defs.vh ====
`ifndef RXQ2_DEFS_VH
`define RXQ2_DEFS_VH

// Register byte addresses
`define RXQ2_ADDR_INDEX_PAIR  12'h0ec
`define RXQ2_ADDR_STATE_DROPS 12'h0f0
`define RXQ2_ADDR_CONTROL     12'h100
`define RXQ2_ADDR_IRQ_STATUS  12'h104
`define RXQ2_ADDR_IRQ_MASK    12'h108

// Index pair fields
`define RXQ2_FETCH_MSB        26
`define RXQ2_FETCH_LSB        16
`define RXQ2_POST_MSB         10
`define RXQ2_POST_LSB         0
`define RXQ2_INDEX_W          11

// State and drops fields
`define RXQ2_NO_BURST_BIT     16
`define RXQ2_DROPS_MSB        15
`define RXQ2_DIAG_LSB         17

// Control fields
`define RXQ2_CTRL_FETCH_WE    0
`define RXQ2_CTRL_DMA_EN      1

// Interrupt status bits
`define RXQ2_IRQ_DROP         0
`define RXQ2_IRQ_BAD_FRAME    1
`define RXQ2_IRQ_EMPTY        2
`define RXQ2_IRQ_W            3

// Reset values
`define RXQ2_RESET_WORD       32'h00000000

// Bus responses
`define RXQ2_RESP_OKAY        2'b00
`define RXQ2_RESP_SLVERR      2'b10

`endif

// ==== rtl/rxq2_engine.v ====
`timescale 1ns/1ps
`default_nettype none

module rxq2_engine
(
    // Clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // Control
    input  wire       dma_enable,
    input  wire       desc_ok,
    // Burst handshake with the data mover
    input  wire       burst_request,
    input  wire       burst_done,
    output reg        burst_start_reg,
    // Status
    output reg        no_burst_reg,
    output reg  [1:0] state_reg
);

    localparam [1:0] S_READY = 2'b00;
    localparam [1:0] S_BURST = 2'b01;
    localparam [1:0] S_HALT  = 2'b10;

    reg [1:0] state_next;
    reg       start_next;

    always @*
    begin
        state_next = state_reg;
        start_next = 1'b0;
        case (state_reg)
            S_READY:
            begin
                if (!dma_enable)
                    state_next = S_HALT;
                else if (burst_request && desc_ok)
                begin
                    state_next = S_BURST;
                    start_next = 1'b1;
                end
            end
            S_BURST:
            begin
                // A burst in flight always completes; disabling only stops the next one
                if (burst_done)
                    state_next = dma_enable ? S_READY : S_HALT;
            end
            S_HALT:
            begin
                if (dma_enable)
                    state_next = S_READY;
            end
            default:
                state_next = S_HALT;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg       <= S_HALT;
            burst_start_reg <= 1'b0;
            no_burst_reg    <= 1'b1;
        end
        else
        begin
            state_reg       <= state_next;
            burst_start_reg <= start_next;
            no_burst_reg    <= (state_next != S_READY);
        end
    end

endmodule // rxq2_engine

`default_nettype wire

// ==== rtl/rxq2_top.v ====
// How it works
// - Device advances fetch index per fetched descriptor.
// - Status bit shows no burst can start.
// - Disabled with no-burst set: no new burst.
// - Count frames dropped for lack of descriptors.
// - Upper status bits are read-only diagnostics.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rxq2_defs.vh"

module rxq2_top
(
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Receive datapath events
    input  wire        desc_fetched,
    input  wire        frame_start,
    input  wire        frame_bad,
    input  wire        frame_dropped_no_desc,
    // Burst handshake
    input  wire        burst_request,
    input  wire        burst_done,
    output wire        burst_start,
    // Descriptor availability and interrupt
    output reg         desc_available,
    output reg         irq
);

    reg  [10:0] fetch_index_reg;
    reg  [10:0] post_index_reg;
    reg  [10:0] frame_base_reg;
    reg  [15:0] drops_reg;
    reg  [1:0]  control_reg;
    reg  [2:0]  irq_status_reg;
    reg  [2:0]  irq_mask_reg;
    reg         empty_d_reg;
    reg  [11:0] awaddr_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;

    wire        no_burst;
    wire [1:0]  engine_state;

    function [31:0] strb_mask;
        input [3:0] strb;
        begin
            strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        end
    endfunction

    function [31:0] merge;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0]  strb;
        begin
            merge = (old_word & ~strb_mask(strb)) | (new_word & strb_mask(strb));
        end
    endfunction

    function mapped;
        input [11:0] addr;
        begin
            if (addr == `RXQ2_ADDR_INDEX_PAIR)
                mapped = 1'b1;
            else if (addr == `RXQ2_ADDR_STATE_DROPS)
                mapped = 1'b1;
            else if (addr == `RXQ2_ADDR_CONTROL)
                mapped = 1'b1;
            else if (addr == `RXQ2_ADDR_IRQ_STATUS)
                mapped = 1'b1;
            else if (addr == `RXQ2_ADDR_IRQ_MASK)
                mapped = 1'b1;
            else
                mapped = 1'b0;
        end
    endfunction

    // Word images as software sees them
    wire [31:0] pair_word  = {5'h00, fetch_index_reg, 5'h00, post_index_reg};
    // Diagnostic field carries the engine state; nothing above it is promised
    wire [31:0] state_word = {13'h0000, engine_state, no_burst, drops_reg};
    wire [31:0] ctrl_word  = {30'h00000000, control_reg};
    wire [31:0] ists_word  = {29'h00000000, irq_status_reg};
    wire [31:0] imsk_word  = {29'h00000000, irq_mask_reg};

    wire        queue_empty = (fetch_index_reg == post_index_reg);
    wire        fetch_take  = desc_fetched && !queue_empty;

    // Write is performed once both address and data are held and no response is pending
    wire        do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire        wr_pair  = do_write && (awaddr_reg == `RXQ2_ADDR_INDEX_PAIR);
    wire        wr_state = do_write && (awaddr_reg == `RXQ2_ADDR_STATE_DROPS);
    wire        wr_ctrl  = do_write && (awaddr_reg == `RXQ2_ADDR_CONTROL);
    wire        wr_ists  = do_write && (awaddr_reg == `RXQ2_ADDR_IRQ_STATUS);
    wire        wr_imsk  = do_write && (awaddr_reg == `RXQ2_ADDR_IRQ_MASK);

    wire [31:0] pair_new  = merge(pair_word, wdata_reg, wstrb_reg);
    wire [31:0] state_new = merge(state_word, wdata_reg, wstrb_reg);
    wire [31:0] ctrl_new  = merge(ctrl_word, wdata_reg, wstrb_reg);
    wire [31:0] imsk_new  = merge(imsk_word, wdata_reg, wstrb_reg);
    wire [2:0]  ists_clr  = wr_ists ? (wdata_reg[2:0] & {3{wstrb_reg[0]}}) : 3'h0;

    wire [2:0]  irq_event;
    assign irq_event[`RXQ2_IRQ_DROP]      = frame_dropped_no_desc;
    assign irq_event[`RXQ2_IRQ_BAD_FRAME] = frame_bad;
    assign irq_event[`RXQ2_IRQ_EMPTY]     = queue_empty && !empty_d_reg;

    reg  [10:0] fetch_next;
    reg  [10:0] post_next;
    reg  [15:0] drops_base;
    reg  [2:0]  irq_status_next;

    always @*
    begin
        fetch_next = fetch_index_reg;
        if (frame_bad)
            fetch_next = frame_base_reg;
        else if (wr_pair && control_reg[`RXQ2_CTRL_FETCH_WE])
            fetch_next = pair_new[`RXQ2_FETCH_MSB:`RXQ2_FETCH_LSB];
        else if (fetch_take)
            fetch_next = fetch_index_reg + 11'h001;
        post_next = wr_pair ? pair_new[`RXQ2_POST_MSB:`RXQ2_POST_LSB] : post_index_reg;
        drops_base = wr_state ? state_new[`RXQ2_DROPS_MSB:0] : drops_reg;
        // Set wins over a simultaneous write-one-to-clear
        irq_status_next = (irq_status_reg & ~ists_clr) | irq_event;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fetch_index_reg <= 11'h000;
            post_index_reg  <= 11'h000;
            frame_base_reg  <= 11'h000;
            drops_reg       <= 16'h0000;
            control_reg     <= 2'h0;
            irq_status_reg  <= 3'h0;
            irq_mask_reg    <= 3'h0;
            empty_d_reg     <= 1'b1;
            desc_available  <= 1'b0;
            irq             <= 1'b0;
        end
        else
        begin
            fetch_index_reg <= fetch_next;
            if (frame_start)
                frame_base_reg <= fetch_index_reg;
            post_index_reg <= post_next;
            // Counter wraps at 16 bits; a software write reloads it
            drops_reg <= drops_base + {15'h0000, frame_dropped_no_desc};
            if (wr_ctrl)
                control_reg <= ctrl_new[1:0];
            if (wr_imsk)
                irq_mask_reg <= imsk_new[2:0];
            irq_status_reg <= irq_status_next;
            empty_d_reg    <= queue_empty;
            // Both next values, so the flag tracks the indices in the same cycle
            desc_available <= (fetch_next != post_next);
            irq            <= |(irq_status_next & irq_mask_reg);
        end
    end

    rxq2_engine u_engine
    (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .dma_enable      (control_reg[`RXQ2_CTRL_DMA_EN]),
        .desc_ok         (!queue_empty),
        .burst_request   (burst_request),
        .burst_done      (burst_done),
        .burst_start_reg (burst_start),
        .no_burst_reg    (no_burst),
        .state_reg       (engine_state)
    );

    // AXI4-Lite write side
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RXQ2_RESP_OKAY;
            awaddr_reg    <= 12'h000;
            wdata_reg     <= `RXQ2_RESET_WORD;
            wstrb_reg     <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_reg    <= {s_axi_awaddr[11:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(awaddr_reg) ? `RXQ2_RESP_OKAY : `RXQ2_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    wire [11:0] araddr_word = {s_axi_araddr[11:2], 2'b00};

    // AXI4-Lite read side
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `RXQ2_RESET_WORD;
            s_axi_rresp   <= `RXQ2_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RXQ2_RESP_OKAY;
            if (araddr_word == `RXQ2_ADDR_INDEX_PAIR)
                s_axi_rdata <= pair_word;
            else if (araddr_word == `RXQ2_ADDR_STATE_DROPS)
                s_axi_rdata <= state_word;
            else if (araddr_word == `RXQ2_ADDR_CONTROL)
                s_axi_rdata <= ctrl_word;
            else if (araddr_word == `RXQ2_ADDR_IRQ_STATUS)
                s_axi_rdata <= ists_word;
            else if (araddr_word == `RXQ2_ADDR_IRQ_MASK)
                s_axi_rdata <= imsk_word;
            else
            begin
                s_axi_rdata <= `RXQ2_RESET_WORD;
                s_axi_rresp <= `RXQ2_RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // rxq2_top

`default_nettype wire

// ==== tb/rxq2_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rxq2_defs.vh"
module rxq2_props
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // Datapath
    input wire logic        frame_bad,
    input wire logic        burst_request,
    input wire logic        burst_start,
    input wire logic        desc_available
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h0fc
        |=> s_axi_rresp == `RXQ2_RESP_SLVERR) else $error("unmapped read not refused");
    a_ar_blocked: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
        else $error("second read accepted");
    a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_burst_pulse: assert property (burst_start |=> !burst_start)
        else $error("burst start longer than one cycle");
    a_burst_cause: assert property (burst_start |-> $past(burst_request))
        else $error("burst without request");
    a_empty_holds: assert property (!desc_available && !(s_axi_wvalid && s_axi_wready)
        && !$past(s_axi_wvalid && s_axi_wready) && !frame_bad && !$past(frame_bad)
        |=> !desc_available) else $error("empty queue moved");
endmodule // rxq2_props
bind rxq2_top rxq2_props i_rxq2_props
(
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp,
    .s_axi_rvalid, .frame_bad, .burst_request, .burst_start, .desc_available
);
`default_nettype wire

// ==== tb/rxq2_dp_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rxq2_dp_model
(
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Bench control: wish to move data, burst length in cycles
    input wire logic       want,
    input wire logic [3:0] lag,
    // Burst handshake
    input wire logic       burst_start,
    output var logic       burst_request,
    output var logic       burst_done
);
    logic [3:0] left_reg;
    logic       busy_reg;
    // Request held until granted, then dropped for the burst
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            busy_reg <= 1'b0;
            burst_request <= 1'b0;
            left_reg <= 4'h0;
        end
        else if (burst_start)
        begin
            busy_reg <= 1'b1;
            burst_request <= 1'b0;
            left_reg <= lag;
        end
        else if (busy_reg)
        begin
            left_reg <= left_reg - 4'h1;
            busy_reg <= (left_reg != 4'h0);
        end
        else
            burst_request <= want;
    end
    // Done pulses once, in the cycle after the count runs out
    always_ff @(posedge aclk)
        burst_done <= aresetn && busy_reg && !burst_start && left_reg == 4'h0;
    // Host keeps its ring on a 256-byte boundary; only indices cross here
endmodule // rxq2_dp_model
`default_nettype wire

// ==== tb/rxq2_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module rxq2_top_tb;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d, m; logic [1:0] r;} rxq2_row_t;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, want;
    logic        s_axi_bready, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, burst_request, burst_done, burst_start;
    logic        desc_available, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  ev, lag, s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    integer      mismatches, cmp_count, n;
    rxq2_row_t   rows [13] = '{
        '{0, 12'h0ec, 32'h0, 32'hffffffff, 2'h0},
        '{0, 12'h0f0, 32'h00010000, 32'h0001ffff, 2'h0},
        '{1, 12'h0ec, 32'h07ff0005, 32'h0, 2'h0},
        '{0, 12'h0ec, 32'h00000005, 32'hffffffff, 2'h0},
        '{1, 12'h100, 32'h1, 32'h0, 2'h0},
        '{1, 12'h0ec, 32'h00030005, 32'h0, 2'h0},
        '{0, 12'h0ec, 32'h00030005, 32'hffffffff, 2'h0},
        '{1, 12'h100, 32'h0, 32'h0, 2'h0},
        '{1, 12'h0f0, 32'hffffffff, 32'h0, 2'h0},
        '{0, 12'h0f0, 32'h0001ffff, 32'hfff9ffff, 2'h0},
        '{0, 12'h0fc, 32'h0, 32'hffffffff, 2'h2},
        '{1, 12'h0fc, 32'h1, 32'h0, 2'h2},
        '{1, 12'h108, 32'h7, 32'h0, 2'h0}};

    rxq2_top i_rxq2_top
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .desc_fetched(ev[3]),
        .frame_start(ev[2]), .frame_bad(ev[1]), .frame_dropped_no_desc(ev[0]),
        .burst_request, .burst_done, .burst_start, .desc_available, .irq
    );
    rxq2_dp_model i_rxq2_dp_model
    (
        .aclk, .aresetn, .want, .lag, .burst_start, .burst_request, .burst_done
    );

    task wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task hang(input integer k);
        if (k >= 40)
        begin
            mismatches++;
            wrap_up();
        end
    endtask
    task axi_wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1 && n < 40);
        rs = s_axi_bresp;
        hang(n);
    endtask
    task axi_rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1 && n < 40);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        hang(n);
    endtask
    task pulse(input logic [3:0] v);
        ev <= v;
        @(posedge aclk);
        ev <= 4'h0;
        repeat (2) @(posedge aclk);
    endtask
    task wait_burst;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (burst_start !== 1'b1 && n < 40);
        hang(n);
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    initial
    begin
        {mismatches, cmp_count} = 0;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, want, ev} = 0;
        {s_axi_bready, s_axi_rready, lag, s_axi_wstrb} = 10'h38f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("irq", irq, 0);
        foreach (rows[i])
        begin
            if (rows[i].w)
                axi_wr(rows[i].a, rows[i].d);
            else
                axi_rd(rows[i].a);
            if (!rows[i].w)
                chk("rdata", rd & rows[i].m, rows[i].d);
            chk("resp", rs, rows[i].r);
        end
        // Drop wraps the counter and raises the interrupt; then mask and clear
        pulse(4'h1);
        axi_rd(12'h0f0);
        chk("drops", rd[15:0], 0);
        chk("irq", irq, 1);
        axi_wr(12'h108, 32'h0);
        pulse(4'h0);
        chk("irq", irq, 0);
        axi_wr(12'h104, 32'h1);
        axi_wr(12'h108, 32'h7);
        pulse(4'h0);
        chk("irq", irq, 0);
        // A write with only byte lane one enabled leaves the mask alone
        s_axi_wstrb <= 4'h2;
        axi_wr(12'h108, 32'h0);
        s_axi_wstrb <= 4'hf;
        axi_rd(12'h108);
        chk("mask", rd, 32'h7);
        // Frame base taken with a fetch; fetch on an empty queue is ignored
        pulse(4'hc);
        pulse(4'h8);
        pulse(4'h8);
        axi_rd(12'h0ec);
        chk("index", rd, 32'h00050005);
        chk("avail", desc_available, 0);
        axi_rd(12'h104);
        chk("status", rd[2:0], 3'h4);
        pulse(4'h2);
        axi_rd(12'h0ec);
        chk("index", rd, 32'h00030005);
        // Slow burst first, none while disabled, then a prompt one
        want <= 1'b1;
        axi_wr(12'h100, 32'h2);
        wait_burst();
        chk("start", burst_start, 1);
        axi_rd(12'h0f0);
        chk("no_burst", rd[16], 1);
        lag <= 4'h0;
        axi_wr(12'h100, 32'h0);
        repeat (12) @(posedge aclk);
        n = 0;
        repeat (30)
        begin
            @(posedge aclk);
            n = n + (burst_start === 1'b1);
        end
        chk("starts", n, 0);
        axi_rd(12'h0f0);
        chk("no_burst", rd[16], 1);
        axi_wr(12'h100, 32'h2);
        wait_burst();
        chk("start", burst_start, 1);
        // Reset in mid-burst returns indices, counter and engine to rest
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("irq", irq, 0);
        chk("avail", desc_available, 0);
        axi_rd(12'h0ec);
        chk("index", rd, 32'h0);
        axi_rd(12'h0f0);
        chk("state", rd & 32'h0001ffff, 32'h00010000);
        wrap_up();
    end
endmodule // rxq2_top_tb
`default_nettype wire
